// [label_text_serializer_consts.svh]
`ifndef LABEL_TEXT_SERIALIZER_CONSTS_SVH
`define LABEL_TEXT_SERIALIZER_CONSTS_SVH
// ----------------------------------------------------------------
// Register map.
// ----------------------------------------------------------------
`define LTS_ADDR_W 12
`define LTS_OFS_CTRL 12'h000
`define LTS_OFS_RATE 12'h004
`define LTS_OFS_STATUS 12'h008
`define LTS_CTRL_RESET 1'b1
`define LTS_RATE_RESET 8'h1e
`define LTS_CTRL_BLINK_EN_BIT 0
`define LTS_STAT_LINE_LSB 0
`define LTS_STAT_LINE_MSB 2
`define LTS_STAT_WAVE_BIT 4
`define LTS_STAT_EMPTY_BIT 8
`define LTS_STAT_READY_BIT 9
`define LTS_STAT_ACTIVE_BIT 12
// ----------------------------------------------------------------
// Character cell timing and fields.
// ----------------------------------------------------------------
`define LTS_DIV_PRESET 3'h5
`define LTS_DIV_GLYPH_ADDR 3'h4
`define LTS_DIV_GLYPH_TAKE 3'h2
`define LTS_DIV_LOAD_REQ 3'h0
`define LTS_CHAR_BLINK_BIT 7
`define LTS_CHAR_CODE_MSB 5
`define LTS_FIFO_DEPTH 16
`define LTS_FIFO_AW 4
// ----------------------------------------------------------------
// Blink timing: one tick is half of the shortest blink cycle.
// ----------------------------------------------------------------
`define LTS_CLK_PERIOD_NS 4
`define LTS_BLINK_TICK_NS 16666667
`define LTS_BLINK_TICK_CYCLES (`LTS_BLINK_TICK_NS / `LTS_CLK_PERIOD_NS)
`endif

// [label_text_serializer_pkg.sv]
package label_text_serializer_pkg;
	typedef enum logic [1:0] {
		FIELD_IDLE = 2'b01,
		FIELD_ACTIVE = 2'b10
	} field_state_t;
	typedef logic [5:0] glyph_row_t;
	typedef logic [7:0] char_byte_t;
	typedef logic [2:0] line_count_t;
endpackage

// [lts_char_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module lts_char_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_in_data,
	input wire logic i_in_valid,
	output logic o_in_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic o_out_valid,
	input wire logic i_out_ready
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] count;
		logic in_ready;
	} fifo_state_t;

	fifo_state_t st_reg;
	fifo_state_t st_next;
	logic push;
	logic pop;

	// Ready is kept in a flop so the fill side never sees a combinational path.
	assign push = i_in_valid && st_reg.in_ready;
	assign pop = i_out_ready && (st_reg.count != '0);

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wp] = i_in_data;
			st_next.wp = AW'(st_reg.wp + 1'b1);
		end
		if (pop) begin
			st_next.rp = AW'(st_reg.rp + 1'b1);
		end
		if (push && !pop) begin
			st_next.count = (AW+1)'(st_reg.count + 1'b1);
		end else if (pop && !push) begin
			st_next.count = (AW+1)'(st_reg.count - 1'b1);
		end
		st_next.in_ready = (st_next.count != (AW+1)'(DEPTH));
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
			st_reg.in_ready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_in_ready = st_reg.in_ready;
	assign o_out_data = st_reg.mem[st_reg.rp];
	assign o_out_valid = (st_reg.count != '0);
endmodule
`default_nettype wire

// [lts_blink_gen.sv]
`timescale 1ns/10ps
`default_nettype none
module lts_blink_gen #(
	parameter int TICK_CYCLES = 4166666
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic [7:0] i_rate,
	output logic o_wave
);
	typedef struct packed {
		logic [31:0] prescale;
		logic [7:0] halves;
		logic wave;
	} blink_state_t;

	blink_state_t st_reg;
	blink_state_t st_next;
	logic [7:0] rate_eff;

	// A rate of zero would stall the wave, so it is treated as the fastest rate.
	assign rate_eff = (i_rate == 8'h00) ? 8'h01 : i_rate;

	always_comb begin
		st_next = st_reg;
		if (!i_enable) begin
			st_next = '0;
		end else if (st_reg.prescale >= 32'(TICK_CYCLES - 1)) begin
			st_next.prescale = 32'h0;
			// Both halves count the same number of ticks.
			if (8'(st_reg.halves + 8'h01) >= rate_eff) begin
				st_next.halves = 8'h00;
				st_next.wave = !st_reg.wave;
			end else begin
				st_next.halves = 8'(st_reg.halves + 8'h01);
			end
		end else begin
			st_next.prescale = 32'(st_reg.prescale + 32'h1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_wave = st_reg.wave;
endmodule
`default_nettype wire

// [label_text_serializer.sv]
// Notes on behaviour
// - A 3-bit line count runs only inside the label field and picks the glyph row fetched.
// - Inside the field the line count steps by one on each rising edge of the line strobe.
// - The shift register is always either loading or shifting, chosen only by its load level.
// - With load low, the next glyph row is captured at the following clock edge.
// - With load high, the contents move one place toward the pixel output each clock edge.
// - A zero enters behind every shifted bit, so an unreloaded register drains to background.
// - While a character blinks, its reload is withheld so background replaces the glyph.
// - Blink is active only when the blink wave and the character's flag bit are both high.
// - Only the low six bits of a character byte form the glyph code; bit six is ignored.
// - The blink wave is a square wave with equal high and low halves.
// - The blink period is set by a register and covers one thirtieth to 8.5 seconds.
// - The blink wave is also driven out to select between two enhancement table sets.
// - A pixel divider preset to five underflows every sixth clock, reloads and asks for a load.
// - Each glyph row is six bits wide, one bit per pixel of the character cell.
// - The eight line counts, from the first field line on, all fetch their glyph row from the table.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "label_text_serializer_consts.svh"
module label_text_serializer #(
	parameter int BLINK_TICK_CYCLES = `LTS_BLINK_TICK_CYCLES
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic I_FIELD_EN,
	input wire logic I_LINE_STROBE,
	input wire logic [7:0] I_CHAR_BYTE,
	input wire logic I_CHAR_VALID,
	output logic O_CHAR_READY,
	output logic [8:0] O_GLYPH_ADDR,
	input wire logic [5:0] I_GLYPH_ROW,
	output logic O_LABEL_PIXEL,
	output logic O_BLINK_WAVE,
	output logic [2:0] O_LINE_COUNT,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic O_PREADY,
	output logic [31:0] O_PRDATA,
	output logic O_PSLVERR
);
	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic en_meta;
		logic en_sync;
		logic strobe_meta;
		logic strobe_sync;
		logic strobe_prev;
		label_text_serializer_pkg::field_state_t state;
		label_text_serializer_pkg::line_count_t line;
		logic [2:0] div;
		label_text_serializer_pkg::char_byte_t cur_char;
		logic [8:0] glyph_addr;
		label_text_serializer_pkg::glyph_row_t glyph_hold;
		label_text_serializer_pkg::glyph_row_t shifter;
		logic load_n;
		logic blink_en;
		logic [7:0] rate;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} core_state_t;

	core_state_t st_reg;
	core_state_t st_next;
	logic active;
	logic strobe_rise;
	logic blink_wave;
	logic blink_hit;
	logic fifo_valid;
	logic fifo_pop;
	logic fifo_ready;
	label_text_serializer_pkg::char_byte_t fifo_data;
	logic apb_setup;
	logic apb_write;

	// ----------------------------------------------------------------
	// Character buffer and blink generator.
	// ----------------------------------------------------------------
	lts_char_fifo #(
		.WIDTH(8),
		.DEPTH(`LTS_FIFO_DEPTH),
		.AW(`LTS_FIFO_AW)
	) u_fifo (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_in_data(I_CHAR_BYTE),
		.i_in_valid(I_CHAR_VALID),
		.o_in_ready(fifo_ready),
		.o_out_data(fifo_data),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_pop)
	);

	lts_blink_gen #(
		.TICK_CYCLES(BLINK_TICK_CYCLES)
	) u_blink (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_enable(st_reg.blink_en),
		.i_rate(st_reg.rate),
		.o_wave(blink_wave)
	);

	// ----------------------------------------------------------------
	// Combinational terms.
	// ----------------------------------------------------------------
	assign active = (st_reg.state == label_text_serializer_pkg::FIELD_ACTIVE);
	assign strobe_rise = st_reg.strobe_sync && !st_reg.strobe_prev;
	// Characters are drained only inside the field, which is what lets the buffer fill ahead.
	assign fifo_pop = active && st_reg.en_sync && (st_reg.div == `LTS_DIV_PRESET);
	assign blink_hit = blink_wave && st_reg.cur_char[`LTS_CHAR_BLINK_BIT];
	assign apb_setup = I_PSEL && !I_PENABLE;
	assign apb_write = I_PSEL && I_PENABLE && st_reg.pready && I_PWRITE;

	always_comb begin
		st_next = st_reg;
		st_next.en_meta = I_FIELD_EN;
		st_next.en_sync = st_reg.en_meta;
		st_next.strobe_meta = I_LINE_STROBE;
		st_next.strobe_sync = st_reg.strobe_meta;
		st_next.strobe_prev = st_reg.strobe_sync;
		st_next.load_n = 1'b1;

		case (st_reg.state)
			label_text_serializer_pkg::FIELD_IDLE: begin
				st_next.line = 3'h0;
				st_next.div = `LTS_DIV_PRESET;
				if (st_reg.en_sync) begin
					st_next.state = label_text_serializer_pkg::FIELD_ACTIVE;
				end
			end
			label_text_serializer_pkg::FIELD_ACTIVE: begin
				if (!st_reg.en_sync) begin
					st_next.state = label_text_serializer_pkg::FIELD_IDLE;
					st_next.line = 3'h0;
					st_next.div = `LTS_DIV_PRESET;
				end else begin
					if (strobe_rise) begin
						st_next.line = 3'(st_reg.line + 3'h1);
					end
					if (st_reg.div == 3'h0) begin
						st_next.div = `LTS_DIV_PRESET;
					end else begin
						st_next.div = 3'(st_reg.div - 3'h1);
					end
					if (st_reg.div == `LTS_DIV_PRESET) begin
						// An empty buffer yields a blank cell rather than stalling the raster.
						st_next.cur_char = fifo_valid ? fifo_data : 8'h00;
					end
					if (st_reg.div == `LTS_DIV_GLYPH_ADDR) begin
						st_next.glyph_addr = {st_reg.cur_char[`LTS_CHAR_CODE_MSB:0], st_reg.line};
					end
					if (st_reg.div == `LTS_DIV_GLYPH_TAKE) begin
						st_next.glyph_hold = I_GLYPH_ROW;
					end
					if (st_reg.div == `LTS_DIV_LOAD_REQ && !blink_hit) begin
						st_next.load_n = 1'b0;
					end
				end
			end
			default: begin
				st_next.state = label_text_serializer_pkg::FIELD_IDLE;
			end
		endcase

		if (!st_reg.load_n) begin
			st_next.shifter = st_reg.glyph_hold;
		end else begin
			st_next.shifter = {1'b0, st_reg.shifter[5:1]};
		end

		// ----------------------------------------------------------------
		// Register bus: zero wait states, answer prepared in the setup cycle.
		// ----------------------------------------------------------------
		st_next.pready = apb_setup;
		if (apb_setup) begin
			st_next.prdata = 32'h0;
			st_next.pslverr = 1'b0;
			case (I_PADDR)
				`LTS_OFS_CTRL: begin
					st_next.prdata[`LTS_CTRL_BLINK_EN_BIT] = st_reg.blink_en;
				end
				`LTS_OFS_RATE: begin
					st_next.prdata[7:0] = st_reg.rate;
				end
				`LTS_OFS_STATUS: begin
					st_next.prdata[`LTS_STAT_LINE_MSB:`LTS_STAT_LINE_LSB] = st_reg.line;
					st_next.prdata[`LTS_STAT_WAVE_BIT] = blink_wave;
					st_next.prdata[`LTS_STAT_EMPTY_BIT] = !fifo_valid;
					st_next.prdata[`LTS_STAT_READY_BIT] = fifo_ready;
					st_next.prdata[`LTS_STAT_ACTIVE_BIT] = active;
				end
				default: begin
					st_next.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_write) begin
			if (I_PADDR == `LTS_OFS_CTRL) begin
				st_next.blink_en = I_PWDATA[`LTS_CTRL_BLINK_EN_BIT];
			end
			if (I_PADDR == `LTS_OFS_RATE) begin
				st_next.rate = I_PWDATA[7:0];
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st_reg <= '0;
			st_reg.state <= label_text_serializer_pkg::FIELD_IDLE;
			st_reg.div <= `LTS_DIV_PRESET;
			st_reg.load_n <= 1'b1;
			st_reg.blink_en <= `LTS_CTRL_RESET;
			st_reg.rate <= `LTS_RATE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------
	assign O_CHAR_READY = fifo_ready;
	assign O_GLYPH_ADDR = st_reg.glyph_addr;
	assign O_LABEL_PIXEL = st_reg.shifter[0];
	assign O_BLINK_WAVE = blink_wave;
	assign O_LINE_COUNT = st_reg.line;
	assign O_PREADY = st_reg.pready;
	assign O_PRDATA = st_reg.prdata;
	assign O_PSLVERR = st_reg.pslverr;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RST_N);

	property p_line_clear;
		!st_reg.en_sync |=> (st_reg.line == 3'h0);
	endproperty
	a_line_clear: assert property (p_line_clear) else $error("line count not cleared");

	property p_line_step;
		(active && st_reg.en_sync && strobe_rise) |=> (st_reg.line == 3'($past(st_reg.line) + 3'h1));
	endproperty
	a_line_step: assert property (p_line_step) else $error("line count did not step");

	property p_line_hold;
		(active && st_reg.en_sync && !strobe_rise) |=> $stable(st_reg.line);
	endproperty
	a_line_hold: assert property (p_line_hold) else $error("line count moved without strobe");

	property p_shift;
		st_reg.load_n |=> (st_reg.shifter == {1'b0, $past(st_reg.shifter[5:1])});
	endproperty
	a_shift: assert property (p_shift) else $error("shift mode did not shift in zero");

	property p_load;
		!st_reg.load_n |=> (st_reg.shifter == $past(st_reg.glyph_hold));
	endproperty
	a_load: assert property (p_load) else $error("load mode did not capture glyph row");

	property p_blink_inhibit;
		(active && st_reg.en_sync && st_reg.div == 3'h0 && blink_hit) |=> st_reg.load_n;
	endproperty
	a_blink_inhibit: assert property (p_blink_inhibit) else $error("blinking cell reloaded");

	property p_load_request;
		(active && st_reg.en_sync && st_reg.div == 3'h0 && !blink_hit)
			|=> (!st_reg.load_n && st_reg.div == 3'h5);
	endproperty
	a_load_request: assert property (p_load_request) else $error("underflow gave no load");

	property p_cell_period;
		(active && st_reg.en_sync && st_reg.div == 3'h5) ##1 st_reg.en_sync [*5]
			|-> (st_reg.div == 3'h0);
	endproperty
	a_cell_period: assert property (p_cell_period) else $error("cell is not six clocks");

	property p_glyph_addr;
		(active && st_reg.en_sync && st_reg.div == 3'h4)
			|=> (st_reg.glyph_addr == {$past(st_reg.cur_char[5:0]), $past(st_reg.line)});
	endproperty
	a_glyph_addr: assert property (p_glyph_addr) else $error("glyph address wrong");

	property p_apb_ready;
		(I_PSEL && !I_PENABLE) |=> (O_PREADY ##1 !O_PREADY);
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("bus answer not one cycle");

	property p_state_onehot;
		$onehot(st_reg.state);
	endproperty
	a_state_onehot: assert property (p_state_onehot) else $error("field state not one-hot");

	// A withheld reload must leave nothing of the previous glyph behind.
	property p_blank_cell;
		(active && st_reg.en_sync && st_reg.div == `LTS_DIV_LOAD_REQ && blink_hit)
			|-> ##2 (st_reg.shifter == 6'h00);
	endproperty
	a_blank_cell: assert property (p_blank_cell) else $error("blinking cell not blank");

	property p_empty_blank;
		(fifo_pop && !fifo_valid) |=> (st_reg.cur_char == 8'h00);
	endproperty
	a_empty_blank: assert property (p_empty_blank) else $error("empty buffer gave ink");

	property p_pop_char;
		(fifo_pop && fifo_valid) |=> (st_reg.cur_char == $past(fifo_data));
	endproperty
	a_pop_char: assert property (p_pop_char) else $error("popped byte not taken");

	property p_row_take;
		(active && st_reg.en_sync && st_reg.div == `LTS_DIV_GLYPH_TAKE)
			|=> (st_reg.glyph_hold == $past(I_GLYPH_ROW));
	endproperty
	a_row_take: assert property (p_row_take) else $error("glyph row not captured");

	property p_rate_write;
		(apb_write && I_PADDR == `LTS_OFS_RATE) |=> (st_reg.rate == $past(I_PWDATA[7:0]));
	endproperty
	a_rate_write: assert property (p_rate_write) else $error("rate write lost");

	property p_field_entry;
		(!active && st_reg.en_sync)
			|=> (active && st_reg.div == `LTS_DIV_PRESET && st_reg.line == 3'h0);
	endproperty
	a_field_entry: assert property (p_field_entry) else $error("field entry not clean");

	property p_bus_error;
		(apb_setup && I_PADDR != `LTS_OFS_CTRL && I_PADDR != `LTS_OFS_RATE
			&& I_PADDR != `LTS_OFS_STATUS) |=> (O_PSLVERR && O_PRDATA == 32'h0);
	endproperty
	a_bus_error: assert property (p_bus_error) else $error("unmapped access not refused");

	property p_wave_off;
		!st_reg.blink_en |=> !blink_wave;
	endproperty
	a_wave_off: assert property (p_wave_off) else $error("blink wave ran while disabled");

	c_blink_skip: cover property (active && st_reg.div == 3'h0 && blink_hit);
	c_line_wrap: cover property (active && st_reg.line == 3'h7 ##1 st_reg.line == 3'h0);
	c_rate_write: cover property (apb_write && I_PADDR == `LTS_OFS_RATE);
	c_fifo_full: cover property (!fifo_ready);
endmodule
`default_nettype wire

// [glyph_table_model.sv]
`timescale 1ns/10ps
`default_nettype none
module glyph_table_model #(
	parameter int LAG = 1
) (
	input wire logic i_clk,
	input wire logic [8:0] i_addr,
	output logic [5:0] o_row
);
	// ----------------------------------------------------------------
	// Glyph table contents.
	// ----------------------------------------------------------------
	// Code zero is a blank cell, so an empty buffer adds no ink.
	logic [5:0] row_now;
	logic [5:0] row_reg;
	assign row_now = (i_addr[8:3] == 6'h00) ? 6'h00 : i_addr[8:3] ^ {i_addr[2:0], i_addr[2:0]};
	always_ff @(posedge i_clk) begin
		row_reg <= row_now;
	end
	// A lagging table answers one clock late, still before the row is taken.
	assign o_row = (LAG != 0) ? row_reg : row_now;
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
	// ------------------------------------------
	// Pins and bench state.
	// ------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic field_en = 1'b0;
	logic strobe = 1'b0;
	logic [7:0] char_byte = 8'h00;
	logic char_valid = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic char_ready;
	logic pixel;
	logic wave;
	logic pready;
	logic pslverr;
	logic [8:0] glyph_addr;
	logic [8:0] last_addr = 9'h000;
	logic [5:0] glyph_row;
	logic [2:0] line_count;
	logic [31:0] prdata;
	logic [31:0] seed = 32'h00015e9b;
	logic wave_q = 1'b0;
	int wave_run = 0;
	int wave_len [2] = '{0, 0};
	int ones = 0;
	int n_mismatch = 0;
	int tests_run = 0;
	int r;
	logic [8:0] seen [$];

	always #2 clk = ~clk;

	label_text_serializer #(.BLINK_TICK_CYCLES(4)) dut (
		.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_FIELD_EN(field_en), .I_LINE_STROBE(strobe),
		.I_CHAR_BYTE(char_byte), .I_CHAR_VALID(char_valid), .O_CHAR_READY(char_ready),
		.O_GLYPH_ADDR(glyph_addr), .I_GLYPH_ROW(glyph_row), .O_LABEL_PIXEL(pixel),
		.O_BLINK_WAVE(wave), .O_LINE_COUNT(line_count), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
		.O_PRDATA(prdata), .O_PSLVERR(pslverr));

	glyph_table_model #(.LAG(1)) table_model (.i_clk(clk), .i_addr(glyph_addr), .o_row(glyph_row));

	// ------------------------------------------
	// Monitors.
	// ------------------------------------------
	// The pixel count and address list only grow, so the cell test works on differences and never races the monitor.
	always @(posedge clk) begin
		ones <= ones + 32'(pixel);
		wave_q <= wave;
		wave_run <= (wave === wave_q) ? wave_run + 1 : 1;
		if (wave !== wave_q) wave_len[wave_q] <= wave_run;
		if (glyph_addr !== last_addr && glyph_addr[8:3] != 6'h00) seen.push_back(glyph_addr);
		last_addr <= glyph_addr;
	end

	// ------------------------------------------
	// Helpers.
	// ------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
			input logic [31:0] exp_q, input logic exp_e);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		chk(32'(pready), 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		if (!wr) chk(prdata, exp_q);
		chk(32'(pslverr), 32'(exp_e));
	endtask

	task automatic push(input logic [7:0] b);
		int k;
		k = 0;
		@(posedge clk);
		char_valid <= 1'b1;
		char_byte <= b;
		do begin
			@(posedge clk);
			k++;
		end while (char_ready !== 1'b1 && k < 50);
		chk(32'(char_ready), 32'h1);
		char_valid <= 1'b0;
	endtask

	task automatic pulse;
		strobe <= 1'b1;
		cyc(4);
		strobe <= 1'b0;
		cyc(4);
	endtask

	task automatic await(input logic lvl);
		int k;
		k = 0;
		while (wave !== lvl && k < 2500) begin
			@(posedge clk);
			k++;
		end
		chk(32'(wave), 32'(lvl));
	endtask

	task automatic cells(input int n, input logic blink_on);
		logic [7:0] b [$];
		int base_ones;
		int base_n;
		int exp_ones;
		logic [5:0] code;
		base_ones = ones;
		base_n = seen.size();
		exp_ones = 0;
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			// Neighbouring codes differ in parity, so the address monitor sees every cell.
			code = 6'((seed[15:10] % 31) * 2 + i % 2 + 1);
			b.push_back({blink_on ? i[0] : seed[7], seed[6], code});
			push(b[i]);
		end
		cyc(3);
		chk(32'(char_ready), 32'(n < 16));
		field_en <= 1'b1;
		cyc(n * 6 + 40);
		field_en <= 1'b0;
		cyc(5);
		for (int i = 0; i < n; i++) begin
			if (!(blink_on && b[i][7])) exp_ones += $countones(b[i][5:0]);
			chk(32'(seen[base_n + i]), {23'h0, b[i][5:0], 3'h0});
		end
		chk(32'(ones - base_ones), 32'(exp_ones));
		chk(32'(char_ready), 32'h1);
		$display("test cells n=%0d blink=%0d done", n, blink_on);
	endtask

	task automatic conclude;
		$display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------
	// Main sequence.
	// ------------------------------------------
	initial begin
		cyc(10);
		rst_n <= 1'b1;
		cyc(1);
		chk(32'(char_ready), 32'h1);
		chk({29'h0, line_count}, 32'h0);
		chk(32'(wave), 32'h0);
		acc(1'b0, 12'h000, 32'h0, 32'h1, 1'b0);
		acc(1'b0, 12'h004, 32'h0, 32'h1e, 1'b0);
		acc(1'b0, 12'h008, 32'h0, 32'h00000300, 1'b0);
		acc(1'b0, 12'h00c, 32'h0, 32'h0, 1'b1);
		acc(1'b1, 12'h00c, 32'hffffffff, 32'h0, 1'b1);
		acc(1'b1, 12'h008, 32'hffffffff, 32'h0, 1'b0);
		acc(1'b1, 12'h000, 32'h0, 32'h0, 1'b0);
		acc(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
		// Long enough for the wave to have risen had the disable been ignored.
		cyc(130);
		chk(32'(wave), 32'h0);
		$display("test registers done");
		pulse();
		chk(32'(line_count), 32'h0);
		seed = lfsr(seed);
		r = int'(seed[3:0]) + 1;
		field_en <= 1'b1;
		cyc(5);
		repeat (r) pulse();
		cyc(8);
		chk(32'(line_count), 32'(r % 8));
		chk(32'(glyph_addr), 32'(r % 8));
		acc(1'b0, 12'h008, 32'h0, 32'h00001300 | 32'(r % 8), 1'b0);
		field_en <= 1'b0;
		cyc(5);
		chk(32'(line_count), 32'h0);
		$display("test line count done");
		cells(16, 1'b0);
		acc(1'b1, 12'h000, 32'h1, 32'h0, 1'b0);
		repeat (3) begin
			seed = lfsr(seed);
			r = int'(seed[2:0]);
			acc(1'b1, 12'h004, 32'(r), 32'h0, 1'b0);
			if (r == 0) r = 1;
			cyc(24 * r + 80);
			chk(32'(wave_len[1]), 32'(4 * r));
			chk(32'(wave_len[0]), 32'(4 * r));
		end
		$display("test blink period done");
		acc(1'b1, 12'h004, 32'h000000ff, 32'h0, 1'b0);
		acc(1'b0, 12'h004, 32'h0, 32'h000000ff, 1'b0);
		await(1'b0);
		await(1'b1);
		cells(4, 1'b1);
		conclude();
	end

	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
